// ==== verif/dhs_chk.sv ====
`timescale 1ns/1ps
`include "dhs_regs.svh"
module dhs_chk (
	input wire logic                 core_clk_in,
	input wire logic                 rst_in,
	input wire logic                 psel_in,
	input wire logic                 penable_in,
	input wire logic                 pwrite_in,
	input wire logic [11:0]          paddr_in,
	input wire logic [31:0]          pwdata_in,
	input wire logic                 pready_out,
	input wire logic                 auto_manual_select_in,
	input wire logic [4:0]           table_select_low_bits_in,
	input wire logic [2:0]           table_select_high_bits_in,
	input wire logic                 pos_speed_source_select_in,
	input wire logic                 prox_switch_in,
	input wire dhs_pkg::dhs_motion_t motion_out,
	input wire logic                 homing_busy_out,
	input wire logic                 homing_done_out,
	input wire logic [31:0]          current_pos_out
);
	logic [31:0] hsp, csp, acc, dec, hpos;
	logic [3:0]  mth;
	logic        dir, pol, wr, go, ok, mg, sw;
	assign wr = psel_in && penable_in && pwrite_in && pready_out;
	assign go = wr && paddr_in == `DHS_ADDR_CTRL && pwdata_in[`DHS_CTRL_START] && !homing_busy_out;
	assign ok = auto_manual_select_in && pos_speed_source_select_in && table_select_low_bits_in == 5'h0
		&& table_select_high_bits_in == 3'h0;
	assign mg = mth == `DHS_METHOD_REAR || mth == `DHS_METHOD_COUNT;
	assign sw = prox_switch_in ^ pol;
	// shadow copies of the settings, so outputs can be tied to what software wrote
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			hsp <= `DHS_RST_HSPEED;
			csp <= `DHS_RST_CSPEED;
			mth <= 4'h5;
			{acc, dec, hpos, dir, pol} <= '0;
		end
		else if (wr)
		begin
			case (paddr_in)
				`DHS_ADDR_HSPEED: hsp <= pwdata_in;
				`DHS_ADDR_CSPEED: csp <= pwdata_in;
				`DHS_ADDR_METHOD: mth <= pwdata_in[3:0];
				`DHS_ADDR_ACCEL: acc <= pwdata_in;
				`DHS_ADDR_DECEL: dec <= pwdata_in;
				`DHS_ADDR_HOMEPOS: hpos <= pwdata_in;
				`DHS_ADDR_CTRL: {pol, dir} <= pwdata_in[2:1];
				default: ;
			endcase
		end
	end
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	sequence launch; go && ok && mg; endsequence
	sequence shift; motion_out.valid && $past(motion_out.valid) && $changed(motion_out.speed); endsequence
	AST_START_GO: assert property (launch |-> ##[1:4] motion_out.valid)
		else $error("good start did not move the axis");
	AST_REFUSE: assert property (go && !ok |=> !homing_busy_out [*4])
		else $error("start accepted outside homing mode");
	AST_BAD_METHOD: assert property (go && ok && !mg |=> !motion_out.valid [*4])
		else $error("unknown method moved the axis");
	AST_FAST_SPEED: assert property ($rose(motion_out.valid) |-> motion_out.speed == hsp)
		else $error("first speed is not the homing speed");
	AST_CREEP_SPEED: assert property (shift |-> motion_out.speed == csp)
		else $error("speed after switch is not creep speed");
	AST_CREEP_CAUSE: assert property (shift |-> $past(sw, 4))
		else $error("slowed down without an active switch");
	AST_TABLE_ONE: assert property (motion_out.valid |-> motion_out.accel_time == acc && motion_out.decel_time == dec)
		else $error("wrong ramp times during homing");
	AST_DIR: assert property (motion_out.valid |-> motion_out.dir == dir)
		else $error("wrong homing direction");
	AST_HOME_LOAD: assert property ($rose(homing_done_out) |-> current_pos_out == hpos)
		else $error("home coordinate not loaded");
endmodule : dhs_chk
bind dhs_top dhs_chk chk_u (.*);

// ==== verif/dhs_far.sv ====
`timescale 1ns/1ps
module dhs_far (
	input  wire logic                 core_clk_in,
	input  wire logic                 rst_in,
	input  wire dhs_pkg::dhs_motion_t motion_in,
	input  wire logic                 pol_in,
	output logic                      prox_out,
	output logic                      step_out,
	output logic                      decel_done_out
);
	logic [15:0] cnt;
	logic [2:0]  tmr;
	logic        pv;
	// each run starts parked ahead of the dog; the dog is 30 steps long from step 10
	assign prox_out = (cnt >= 16'd10 && cnt < 16'd40) ^ pol_in;
	always_ff @(posedge core_clk_in)
	begin
		pv <= motion_in.valid;
		decel_done_out <= tmr == 3'h1;
		if (rst_in || !motion_in.valid)
		begin
			cnt <= 16'h0;
			step_out <= 1'b0;
			tmr <= 3'h0;
		end
		else
		begin
			// half rate steps keep the sampling slack of the switch small
			step_out <= !step_out;
			cnt <= cnt + 16'(step_out);
			if (pv && $changed(motion_in.speed))
				tmr <= 3'h5;
			else if (tmr != 3'h0)
				tmr <= tmr - 3'h1;
		end
	end
endmodule : dhs_far

// ==== verif/test_dog_reference_homing_sequencer.sv ====
`timescale 1ns/1ps
`include "dhs_regs.svh"
module test_dog_reference_homing_sequencer;
	logic                 clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, man = 0, src = 0, pol = 0, er, sa;
	logic [11:0]          pa = 12'h000;
	logic [31:0]          pwd = 32'h0, prd, rd, pos;
	logic [4:0]           tlo = 5'h0;
	logic [2:0]           thi = 3'h0;
	logic [3:0]           cm = 4'h5;
	logic                 prdy, perr, prox, step, ddone, busy, done;
	dhs_pkg::dhs_motion_t mo;
	int                   n_fail = 0, total_checks = 0, seen = 0, i;
	dhs_top dut_u (.core_clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
		.paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr),
		.auto_manual_select_in(man), .table_select_low_bits_in(tlo), .table_select_high_bits_in(thi),
		.pos_speed_source_select_in(src), .prox_switch_in(prox), .move_step_in(step),
		.decel_done_in(ddone), .motion_out(mo), .homing_busy_out(busy), .homing_done_out(done),
		.current_pos_out(pos));
	dhs_far far_u (.core_clk_in(clk), .rst_in(rst), .motion_in(mo), .pol_in(pol), .prox_out(prox),
		.step_out(step), .decel_done_out(ddone));
	initial forever #4 clk = ~clk;
	// steps since the reference edge: trailing edge for rear mode, leading edge for count mode
	always @(posedge clk)
	begin
		sa <= prox ^ pol;
		if ((cm == `DHS_METHOD_REAR) ? (sa && !(prox ^ pol)) : (!sa && (prox ^ pol)))
			seen <= 0;
		else if (step)
			seen <= seen + 1;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		{psel, pwr, pa, pwd} <= {1'b1, w, a, d};
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		for (k = 0; prdy !== 1'b1 && k < 99; k++) @(posedge clk);
		if (k == 99)
			n_fail++;
		rd = prd;
		er = perr;
		{psel, pen} <= 2'b00;
	endtask : apb
	task automatic mode(input logic m, input logic s, input logic [4:0] l, input logic [2:0] h);
		{man, src, tlo, thi} <= {m, s, l, h};
		repeat (4) @(posedge clk);
	endtask : mode
	task automatic wait_on(input logic w);
		int k;
		for (k = 0; w && busy !== 1'b1 && k < 20; k++) @(posedge clk);
		if (k == 20)
			n_fail++;
		for (k = 0; done !== 1'b1 && k < 3000; k++) @(posedge clk);
		if (k == 3000)
			n_fail++;
	endtask : wait_on
	task automatic home(input logic [3:0] m, input logic d, input logic ab);
		logic [31:0] ps, hp;
		ps = $urandom_range(16, 24);
		hp = $urandom;
		cm <= m;
		pol <= 1'($urandom);
		apb(1, `DHS_ADDR_HSPEED, 32'h40 + $urandom_range(0, 63));
		apb(1, `DHS_ADDR_CSPEED, $urandom_range(1, 31));
		apb(1, `DHS_ADDR_SHIFT, ps - 32'h8);
		apb(1, `DHS_ADDR_POST, 32'h8);
		apb(1, `DHS_ADDR_HOMEPOS, hp);
		apb(1, `DHS_ADDR_ACCEL, $urandom);
		apb(1, `DHS_ADDR_DECEL, $urandom);
		apb(1, `DHS_ADDR_METHOD, {28'($urandom), m});
		apb(1, `DHS_ADDR_CTRL, {29'h0, pol, d, 1'b1});
		if (ab)
		begin
			repeat (30) @(posedge clk);
			apb(1, `DHS_ADDR_CTRL, {28'h0, 1'b1, pol, d, 1'b0});
			repeat (4) @(posedge clk);
			apb(0, `DHS_ADDR_STATUS, 32'h0);
			chk(rd & 32'h6, 32'h4);
		end
		else
		begin
			wait_on(1);
			chk({31'h0, seen >= ps && seen <= ps + 5}, 32'h1);
			chk(pos, hp);
			chk({30'h0, busy, done}, 32'h1);
			apb(0, `DHS_ADDR_STATUS, 32'h0);
			chk(rd & 32'h3, 32'h1);
		end
	endtask : home
	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : stop_test
	initial
	begin
		repeat (40000) @(posedge clk);
		n_fail++;
		stop_test();
	end
	initial
	begin
		void'($urandom(32'hB92B));
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		apb(0, `DHS_ADDR_HSPEED, 32'h0);
		chk(rd, `DHS_RST_HSPEED);
		apb(0, `DHS_ADDR_CSPEED, 32'h0);
		chk(rd, `DHS_RST_CSPEED);
		apb(0, `DHS_ADDR_METHOD, 32'h0);
		chk(rd, `DHS_RST_METHOD);
		apb(0, 12'h030, 32'h0);
		chk({er, rd}, {1'b1, 32'h0});
		apb(1, `DHS_ADDR_STATUS, 32'h0);
		chk({31'h0, er}, 32'h1);
		for (i = 0; i < 4; i++)
		begin
			mode(i != 0, i != 3, i == 1 ? 5'($urandom_range(1, 31)) : 5'h0, i == 2 ? 3'h4 : 3'h0);
			apb(1, `DHS_ADDR_CTRL, 32'h1);
			repeat (6) @(posedge clk);
			apb(0, `DHS_ADDR_STATUS, 32'h0);
			chk(rd, 32'h4);
		end
		mode(1, 1, 5'h0, 3'h0);
		apb(1, `DHS_ADDR_METHOD, 32'h3);
		apb(1, `DHS_ADDR_CTRL, 32'h1);
		repeat (6) @(posedge clk);
		apb(0, `DHS_ADDR_STATUS, 32'h0);
		chk(rd, 32'h4);
		for (i = 0; i < 6; i++)
			home(i[0] ? `DHS_METHOD_COUNT : `DHS_METHOD_REAR, i[1], i == 5);
		stop_test();
	end
endmodule : test_dog_reference_homing_sequencer

// ==== verilog/dhs_apb.sv ====
`timescale 1ns/1ps
`include "dhs_regs.svh"
module dhs_apb (
	input  wire logic        core_clk_in,
	input  wire logic        rst_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	input  wire logic [31:0] status_in,
	input  wire logic [31:0] curpos_in,
	output logic [31:0]      prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	output logic             start_out,
	output logic             abort_out,
	output logic [31:0]      ctrl_out,
	output logic [31:0]      method_out,
	output logic [31:0]      hspeed_out,
	output logic [31:0]      cspeed_out,
	output logic [31:0]      shift_out,
	output logic [31:0]      post_out,
	output logic [31:0]      homepos_out,
	output logic [31:0]      accel_out,
	output logic [31:0]      decel_out
);
	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] method;
		logic [31:0] hspeed;
		logic [31:0] cspeed;
		logic [31:0] shift;
		logic [31:0] post;
		logic [31:0] homepos;
		logic [31:0] accel;
		logic [31:0] decel;
		logic [31:0] rdata;
		logic        err;
		logic        start;
		logic        abort;
		logic        ack;
	} dhs_apb_state_t;
	dhs_apb_state_t st;
	dhs_apb_state_t next_st;
	logic acc;
	logic wr;
	assign acc = psel_in & penable_in;
	assign wr  = acc & pwrite_in & st.ack;
	always_comb
	begin
		next_st = st;
		next_st.start = 1'b0;
		next_st.abort = 1'b0;
		next_st.err = 1'b0;
		next_st.rdata = 32'h0000_0000;
		next_st.ack = 1'b0;
		// first access cycle decodes into flops, the second completes with pready
		if (acc & ~st.ack)
		begin
			next_st.ack = 1'b1;
			case (paddr_in)
				`DHS_ADDR_CTRL:    next_st.rdata = st.ctrl;
				`DHS_ADDR_METHOD:  next_st.rdata = st.method;
				`DHS_ADDR_HSPEED:  next_st.rdata = st.hspeed;
				`DHS_ADDR_CSPEED:  next_st.rdata = st.cspeed;
				`DHS_ADDR_SHIFT:   next_st.rdata = st.shift;
				`DHS_ADDR_POST:    next_st.rdata = st.post;
				`DHS_ADDR_HOMEPOS: next_st.rdata = st.homepos;
				`DHS_ADDR_ACCEL:   next_st.rdata = st.accel;
				`DHS_ADDR_DECEL:   next_st.rdata = st.decel;
				`DHS_ADDR_STATUS:  next_st.rdata = status_in;
				`DHS_ADDR_CURPOS:  next_st.rdata = curpos_in;
				default:           next_st.err = 1'b1;
			endcase
			if (pwrite_in & ((paddr_in == `DHS_ADDR_STATUS) | (paddr_in == `DHS_ADDR_CURPOS)))
				next_st.err = 1'b1;
		end
		if (wr)
		begin
			case (paddr_in)
				`DHS_ADDR_CTRL:
				begin
					next_st.ctrl = {28'h0, 1'b0, pwdata_in[`DHS_CTRL_POL], pwdata_in[`DHS_CTRL_DIR], 1'b0};
					next_st.start = pwdata_in[`DHS_CTRL_START];
					next_st.abort = pwdata_in[`DHS_CTRL_ABORT];
				end
				`DHS_ADDR_METHOD:  next_st.method = pwdata_in;
				`DHS_ADDR_HSPEED:  next_st.hspeed = pwdata_in;
				`DHS_ADDR_CSPEED:  next_st.cspeed = pwdata_in;
				`DHS_ADDR_SHIFT:   next_st.shift = pwdata_in;
				`DHS_ADDR_POST:    next_st.post = pwdata_in;
				`DHS_ADDR_HOMEPOS: next_st.homepos = pwdata_in;
				`DHS_ADDR_ACCEL:   next_st.accel = pwdata_in;
				`DHS_ADDR_DECEL:   next_st.decel = pwdata_in;
				default:           ;
			endcase
		end
	end
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			st <= '0;
			st.method <= `DHS_RST_METHOD;
			st.hspeed <= `DHS_RST_HSPEED;
			st.cspeed <= `DHS_RST_CSPEED;
		end
		else
			st <= next_st;
	end
	// one wait state buys registered read data and error
	assign pready_out  = st.ack;
	assign prdata_out  = st.rdata;
	assign pslverr_out = st.err;
	assign start_out   = st.start;
	assign abort_out   = st.abort;
	assign ctrl_out    = st.ctrl;
	assign method_out  = st.method;
	assign hspeed_out  = st.hspeed;
	assign cspeed_out  = st.cspeed;
	assign shift_out   = st.shift;
	assign post_out    = st.post;
	assign homepos_out = st.homepos;
	assign accel_out   = st.accel;
	assign decel_out   = st.decel;
endmodule : dhs_apb

// ==== verilog/dhs_pkg.sv ====
package dhs_pkg;
	typedef enum logic [5:0] {
		DHS_IDLE  = 6'b000001,
		DHS_FAST  = 6'b000010,
		DHS_DECEL = 6'b000100,
		DHS_CREEP = 6'b001000,
		DHS_TRAVEL= 6'b010000,
		DHS_DONE  = 6'b100000
	} dhs_state_t;
	typedef struct packed {
		logic        valid;
		logic        dir;
		logic [31:0] speed;
		logic [31:0] accel_time;
		logic [31:0] decel_time;
	} dhs_motion_t;
	typedef struct packed {
		logic        manual;
		logic [7:0]  table_sel;
		logic        src_sel;
	} dhs_mode_t;
endpackage : dhs_pkg

// ==== verilog/dhs_regs.svh ====
`ifndef DHS_REGS_SVH
`define DHS_REGS_SVH
`define DHS_ADDR_CTRL      12'h000
`define DHS_ADDR_METHOD    12'h004
`define DHS_ADDR_HSPEED    12'h008
`define DHS_ADDR_CSPEED    12'h00C
`define DHS_ADDR_SHIFT     12'h010
`define DHS_ADDR_POST      12'h014
`define DHS_ADDR_HOMEPOS   12'h018
`define DHS_ADDR_ACCEL     12'h01C
`define DHS_ADDR_DECEL     12'h020
`define DHS_ADDR_STATUS    12'h024
`define DHS_ADDR_CURPOS    12'h028
`define DHS_CTRL_START     0
`define DHS_CTRL_DIR       1
`define DHS_CTRL_POL       2
`define DHS_CTRL_ABORT     3
`define DHS_METHOD_REAR    4'h5
`define DHS_METHOD_COUNT   4'h6
`define DHS_DONE_BIT       0
`define DHS_BUSY_BIT       1
`define DHS_ERR_BIT        2
`define DHS_RST_HSPEED     32'h0000_0064
`define DHS_RST_CSPEED     32'h0000_000A
`define DHS_RST_METHOD     32'h0000_0005
`endif

// ==== verilog/dhs_sync.sv ====
`timescale 1ns/1ps
module dhs_sync (
	input  wire logic core_clk_in,
	input  wire logic rst_in,
	input  wire logic async_in,
	output logic      sync_out
);
	logic [1:0] stage;
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
			stage <= 2'h0;
		else
			stage <= {stage[0], async_in};
	end
	assign sync_out = stage[1];
endmodule : dhs_sync

// ==== verilog/dhs_top.sv ====
`timescale 1ns/1ps
`include "dhs_regs.svh"
module dhs_top (
	input  wire logic        core_clk_in,
	input  wire logic        rst_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic [31:0]      prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	input  wire logic        auto_manual_select_in,
	input  wire logic [4:0]  table_select_low_bits_in,
	input  wire logic [2:0]  table_select_high_bits_in,
	input  wire logic        pos_speed_source_select_in,
	input  wire logic        prox_switch_in,
	input  wire logic        move_step_in,
	input  wire logic        decel_done_in,
	output dhs_pkg::dhs_motion_t motion_out,
	output logic             homing_busy_out,
	output logic             homing_done_out,
	output logic [31:0]      current_pos_out
);
	logic [31:0] ctrl;
	logic [31:0] method;
	logic [31:0] hspeed;
	logic [31:0] cspeed;
	logic [31:0] shift;
	logic [31:0] post;
	logic [31:0] homepos;
	logic [31:0] accel;
	logic [31:0] decel;
	logic        start;
	logic        abort;
	logic        sw_raw;
	logic [31:0] status;
	typedef struct packed {
		dhs_pkg::dhs_state_t  fsm;
		logic                 rear;
		logic                 sw_prev;
		logic                 done;
		logic                 err;
		logic [31:0]          remain;
		logic [31:0]          pos;
		dhs_pkg::dhs_motion_t mot;
	} dhs_top_state_t;
	dhs_top_state_t st;
	dhs_top_state_t next_st;
	logic        sw_act;
	logic        rise;
	logic        fall;
	logic        mode_ok;
	logic        meth_ok;
	logic [31:0] target;
	dhs_apb u_apb (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.psel_in     (psel_in),
		.penable_in  (penable_in),
		.pwrite_in   (pwrite_in),
		.paddr_in    (paddr_in),
		.pwdata_in   (pwdata_in),
		.status_in   (status),
		.curpos_in   (st.pos),
		.prdata_out  (prdata_out),
		.pready_out  (pready_out),
		.pslverr_out (pslverr_out),
		.start_out   (start),
		.abort_out   (abort),
		.ctrl_out    (ctrl),
		.method_out  (method),
		.hspeed_out  (hspeed),
		.cspeed_out  (cspeed),
		.shift_out   (shift),
		.post_out    (post),
		.homepos_out (homepos),
		.accel_out   (accel),
		.decel_out   (decel)
	);
	// edge is taken where the synchronised sample sees it; home error scales with speed
	dhs_sync u_sync (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.async_in    (prox_switch_in),
		.sync_out    (sw_raw)
	);
	assign sw_act  = sw_raw ^ ctrl[`DHS_CTRL_POL];
	assign rise    = sw_act & ~st.sw_prev;
	assign fall    = ~sw_act & st.sw_prev;
	// mode bits come from the same-clock fieldbus decoder, so no synchroniser
	assign mode_ok = auto_manual_select_in & (table_select_low_bits_in == 5'h00)
		& (table_select_high_bits_in == 3'h0) & pos_speed_source_select_in;
	assign meth_ok = (method[3:0] == `DHS_METHOD_REAR) | (method[3:0] == `DHS_METHOD_COUNT);
	assign target  = post + shift;
	assign status  = {29'h0, st.err, ~st.fsm[0], st.done};
	always_comb
	begin
		next_st = st;
		next_st.sw_prev = sw_act;
		next_st.mot.accel_time = accel;
		next_st.mot.decel_time = decel;
		next_st.mot.dir = ctrl[`DHS_CTRL_DIR];
		if (move_step_in & st.mot.valid)
			next_st.pos = st.mot.dir ? st.pos - 32'h0000_0001 : st.pos + 32'h0000_0001;
		case (st.fsm)
			dhs_pkg::DHS_IDLE:
			begin
				next_st.mot.valid = 1'b0;
				next_st.mot.speed = 32'h0000_0000;
				if (start)
				begin
					if (mode_ok & meth_ok)
					begin
						next_st.done = 1'b0;
						next_st.err = 1'b0;
						next_st.rear = (method[3:0] == `DHS_METHOD_REAR);
						next_st.fsm = dhs_pkg::DHS_FAST;
						next_st.mot.valid = 1'b1;
						next_st.mot.speed = hspeed;
					end
					else
						next_st.err = 1'b1;
				end
			end
			dhs_pkg::DHS_FAST:
			begin
				next_st.mot.speed = hspeed;
				if (rise)
				begin
					next_st.fsm = dhs_pkg::DHS_DECEL;
					next_st.remain = target;
				end
			end
			dhs_pkg::DHS_DECEL:
			begin
				next_st.mot.speed = cspeed;
				if (!st.rear & move_step_in)
					next_st.remain = st.remain - 32'h0000_0001;
				if (decel_done_in)
					next_st.fsm = st.rear ? dhs_pkg::DHS_CREEP : dhs_pkg::DHS_TRAVEL;
			end
			dhs_pkg::DHS_CREEP:
			begin
				next_st.mot.speed = cspeed;
				if (fall)
				begin
					next_st.fsm = dhs_pkg::DHS_TRAVEL;
					next_st.remain = target;
				end
			end
			dhs_pkg::DHS_TRAVEL:
			begin
				// distance counting only, index pulse never consulted
				next_st.mot.speed = cspeed;
				if (st.remain == 32'h0000_0000)
					next_st.fsm = dhs_pkg::DHS_DONE;
				else if (move_step_in)
					next_st.remain = st.remain - 32'h0000_0001;
			end
			dhs_pkg::DHS_DONE:
			begin
				next_st.mot.valid = 1'b0;
				next_st.mot.speed = 32'h0000_0000;
				next_st.pos = homepos;
				next_st.done = 1'b1;
				next_st.fsm = dhs_pkg::DHS_IDLE;
			end
			default:
				next_st.fsm = dhs_pkg::DHS_IDLE;
		endcase
		// an overrun in decel (count mode) underflows remain; clamp so travel ends at once
		if (st.fsm == dhs_pkg::DHS_DECEL && !st.rear && st.remain == 32'h0000_0000)
			next_st.remain = 32'h0000_0000;
		if (abort && st.fsm != dhs_pkg::DHS_IDLE)
		begin
			next_st.fsm = dhs_pkg::DHS_IDLE;
			next_st.mot.valid = 1'b0;
			next_st.mot.speed = 32'h0000_0000;
			next_st.err = 1'b1;
		end
	end
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			st <= '0;
			st.fsm <= dhs_pkg::DHS_IDLE;
		end
		else
			st <= next_st;
	end
	assign motion_out      = st.mot;
	assign homing_busy_out = ~st.fsm[0];
	assign homing_done_out = st.done;
	assign current_pos_out = st.pos;
endmodule : dhs_top
